// file: rtl/parallel_and_fixed_io_ports.sv
// Three 8-bit bidirectional ports and a 7-bit fixed input port behind
// an AXI4-Lite slave. Pins are asynchronous and pass two flip-flops.
// Summary of operation
// R1: Each port direction bit: one makes the pin output, zero input.
// R2: Every 8-bit port has its own 8-bit direction register.
// R3: Reset clears all three direction registers, making all pins inputs.
// R4: Direction registers are writable and read back the last value.
// R5: Data write with direction zero stores latch, pin stays undriven.
// R6: Data write with direction one stores latch and drives the pin.
// R7: Data read returns live pin level where direction is zero.
// R8: Data read returns latch content where direction is one.
// R9: Fixed port is 7-bit input-only, bits 0-5 and 7, sampled continuously. The code samples only on edges with clk_en high.
// R10: Reset disables every serial output driver on the fixed port.
// R11: With receiver and transmitter both on, fixed bits 0 and 1 read zero.
// R12: With SPI off, fixed bits 2 to 5 read the pin levels.
// R13: Fixed port has no latch or writable data; reads give pins only.
// R14: Async serial uses fixed bit 0 as receive, bit 1 as transmit.
// R15: SPI uses fixed bits 2..5 as MISO, MOSI, SCK, SS.
// R16: Reset clears async receiver and transmitter enables.
// R17: Reset clears the SPI system enable.
// R18: Direction and data behaviour apply independently per bit.
// R19: Software loads the output latch before setting a direction bit.
`timescale 1ns/1ps
module parallel_and_fixed_io_ports
  import gpio_ports_pkg::*;
(
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // AXI4-Lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [gpio_ports_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [gpio_ports_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Bidirectional ports, three signals per pin
  input wire logic [7:0] first_port_pins_in,
  output logic [7:0] first_port_pins_out,
  output logic [7:0] first_port_pins_oe,
  input wire logic [7:0] second_port_pins_in,
  output logic [7:0] second_port_pins_out,
  output logic [7:0] second_port_pins_oe,
  input wire logic [7:0] third_port_pins_in,
  output logic [7:0] third_port_pins_out,
  output logic [7:0] third_port_pins_oe,
  // Fixed input port, bit 6 unused
  input wire logic [7:0] fixed_input_pins,
  // Serial unit sharing of fixed port pins
  output logic async_receiver_on,
  output logic async_transmitter_on,
  output logic spi_system_on,
  output logic async_receive_in,
  output logic [3:0] spi_pins_in
);
  import gpio_ports_pkg::*;

  logic [7:0] dir [3];
  logic [7:0] latch [3];
  logic [7:0] pin_meta [3];
  logic [7:0] pin_sync [3];
  logic [7:0] pin_raw [3];
  logic [7:0] port_view [3];
  logic [7:0] fixed_meta;
  logic [7:0] fixed_sync;
  logic [7:0] fixed_view;
  logic [2:0] serial_ctrl;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0;
  logic do_write;
  logic [31:0] next_rdata;
  logic rd_hit;

  assign pin_raw[0] = first_port_pins_in;
  assign pin_raw[1] = second_port_pins_in;
  assign pin_raw[2] = third_port_pins_in;

  // Per-port synchroniser, direction, latch and read view
  for (genvar p = 0; p < 3; p++)
  begin : g_port
    always_ff @(posedge aclk)
    begin
      if (clk_en)
      begin
        pin_meta[p] <= pin_raw[p];
        pin_sync[p] <= pin_meta[p];
      end
    end

    // Direction register, cleared by reset, read back as written
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        dir[p] <= DIR_RESET; // R3
      else if (clk_en && do_write && w_lane0 &&
               aw_addr_q == OFF_A_DIR + ADDR_W'(4 * p))
        dir[p] <= w_data_q[7:0]; // R1 R2 R4
    end

    // Output latch is written regardless of direction; not reset
    always_ff @(posedge aclk)
    begin
      if (clk_en && do_write && w_lane0 &&
          aw_addr_q == OFF_A_DATA + ADDR_W'(4 * p))
        latch[p] <= w_data_q[7:0]; // R5 R6
    end

    // Per-bit read select: latch for outputs, pin for inputs
    assign port_view[p] = (dir[p] & latch[p]) | (~dir[p] & pin_sync[p]); // R7 R8 R18
  end

  // Pin drive registered so outputs come straight from flip-flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      first_port_pins_oe <= 8'h00;
      second_port_pins_oe <= 8'h00;
      third_port_pins_oe <= 8'h00;
      first_port_pins_out <= 8'h00;
      second_port_pins_out <= 8'h00;
      third_port_pins_out <= 8'h00;
    end
    else if (clk_en)
    begin
      first_port_pins_oe <= dir[0]; // R5 R6 R18
      second_port_pins_oe <= dir[1];
      third_port_pins_oe <= dir[2];
      first_port_pins_out <= latch[0] & dir[0]; // R6
      second_port_pins_out <= latch[1] & dir[1];
      third_port_pins_out <= latch[2] & dir[2];
    end
  end

  // Fixed port synchroniser, no data latch
  always_ff @(posedge aclk)
  begin
    if (clk_en)
    begin
      fixed_meta <= fixed_input_pins;
      fixed_sync <= fixed_meta; // R9 R13
    end
  end

  // Fixed port read view with serial sharing
  always_comb
  begin
    fixed_view = fixed_sync & FIXED_MASK; // R9 R13 R12
    if (serial_ctrl[BIT_RX_ON] && serial_ctrl[BIT_TX_ON])
      fixed_view[1:0] = 2'h0; // R11
  end

  // Serial enables, cleared by any reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_ctrl <= SERIAL_CTRL_RESET; // R10 R16 R17
    else if (clk_en && do_write && w_lane0 &&
             aw_addr_q == OFF_SERIAL_CTRL)
      serial_ctrl <= w_data_q[2:0];
  end

  // Hand fixed pins to the serial units
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      async_receiver_on <= 1'b0;
      async_transmitter_on <= 1'b0;
      spi_system_on <= 1'b0;
      async_receive_in <= 1'b0;
      spi_pins_in <= 4'h0;
    end
    else if (clk_en)
    begin
      async_receiver_on <= serial_ctrl[BIT_RX_ON];
      async_transmitter_on <= serial_ctrl[BIT_TX_ON]; // R14
      spi_system_on <= serial_ctrl[BIT_SPI_ON];
      async_receive_in <= fixed_sync[0]; // R14
      spi_pins_in <= fixed_sync[5:2]; // R15
    end
  end

  // Write channel: accept address and data in either order
  assign do_write = aw_held && w_held && !bvalid;
  assign w_lane0 = 1'b1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
    end
    else if (clk_en)
    begin
      awready <= !aw_held && !awready && awvalid && !bvalid;
      wready <= !w_held && !wready && wvalid && !bvalid;
      if (awready && awvalid)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wready && wvalid)
      begin
        w_held <= 1'b1;
        w_data_q <= wstrb[0] ? wdata : {wdata[31:8], 8'h00};
      end
      if (do_write)
      begin
        bvalid <= 1'b1;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bresp <= (aw_addr_q <= OFF_SERIAL_CTRL && aw_addr_q[1:0] == 2'h0
                  && aw_addr_q != OFF_FIXED) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Read decode
  always_comb
  begin
    next_rdata = 32'h00000000;
    rd_hit = 1'b1;
    if (araddr == OFF_A_DATA)
      next_rdata[7:0] = port_view[0];
    else if (araddr == OFF_B_DATA)
      next_rdata[7:0] = port_view[1];
    else if (araddr == OFF_C_DATA)
      next_rdata[7:0] = port_view[2];
    else if (araddr == OFF_FIXED)
      next_rdata[7:0] = fixed_view;
    else if (araddr == OFF_A_DIR)
      next_rdata[7:0] = dir[0]; // R4
    else if (araddr == OFF_B_DIR)
      next_rdata[7:0] = dir[1];
    else if (araddr == OFF_C_DIR)
      next_rdata[7:0] = dir[2];
    else if (araddr == OFF_SERIAL_CTRL)
      next_rdata[2:0] = serial_ctrl;
    else
      rd_hit = 1'b0;
  end

  // Read channel: one-cycle arready, data the cycle after
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else if (clk_en)
    begin
      arready <= arvalid && !arready && !rvalid;
      if (arready && arvalid)
      begin
        rvalid <= 1'b1;
        rdata <= next_rdata;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // Reset leaves every pin an input and every serial unit off
  a_dir_reset_clear: assert property (@(posedge aclk) // R3
    !aresetn |=> dir[0] == DIR_RESET && dir[1] == DIR_RESET &&
    dir[2] == DIR_RESET)
    else $error("direction not cleared by reset");
  a_oe_reset_clear: assert property (@(posedge aclk) // R3 R2
    !aresetn |=> first_port_pins_oe == 8'h00 &&
    second_port_pins_oe == 8'h00 && third_port_pins_oe == 8'h00)
    else $error("pin driven after reset");
  a_serial_reset: assert property (@(posedge aclk) // R17
    !aresetn |=> serial_ctrl == SERIAL_CTRL_RESET ##1 !spi_system_on)
    else $error("serial enables survive reset");
  a_serial_off: assert property (@(posedge aclk) // R10 R16
    !aresetn |=> !async_receiver_on && !async_transmitter_on &&
    !spi_system_on)
    else $error("serial unit enabled during reset");

  // Pin drive follows the direction and latch registers bit by bit
  a_oe_follows_dir: assert property (@(posedge aclk) // R1
    disable iff (!aresetn)
    clk_en && $past(aresetn) |=> first_port_pins_oe == $past(dir[0]))
    else $error("pin enable does not follow direction");
  a_drive_latch: assert property (@(posedge aclk) // R5
    disable iff (!aresetn)
    clk_en |=> (third_port_pins_out & ~$past(dir[2])) == 8'h00)
    else $error("input pin driven");
  a_out_value: assert property (@(posedge aclk) // R6
    disable iff (!aresetn)
    clk_en |=>
    ((second_port_pins_out ^ $past(latch[1])) & $past(dir[1])) == 8'h00)
    else $error("output pin not latch value");

  // Register reads pick latch or pin per bit
  a_read_mix: assert property (@(posedge aclk) // R7 R8 R18
    disable iff (!aresetn)
    clk_en && arready && arvalid && araddr == OFF_A_DATA |=>
    rdata[7:0] == (($past(dir[0]) & $past(latch[0])) |
                   (~$past(dir[0]) & $past(pin_sync[0]))))
    else $error("port read mixes wrong sources");
  a_dir_readback: assert property (@(posedge aclk) // R4
    disable iff (!aresetn)
    clk_en && arready && arvalid && araddr == OFF_B_DIR |=>
    rdata[7:0] == $past(dir[1]))
    else $error("direction read differs from register");

  // Fixed port reads and sharing with the serial units
  a_fixed_zero: assert property (@(posedge aclk) // R11
    disable iff (!aresetn)
    clk_en && arready && arvalid && araddr == OFF_FIXED &&
    serial_ctrl[BIT_RX_ON] && serial_ctrl[BIT_TX_ON] |=> rdata[1:0] == 2'h0)
    else $error("fixed bits 0,1 not zero");
  a_fixed_pins: assert property (@(posedge aclk) // R12
    disable iff (!aresetn)
    clk_en && arready && arvalid && araddr == OFF_FIXED &&
    !serial_ctrl[BIT_SPI_ON] |=> rdata[5:2] == $past(fixed_sync[5:2]))
    else $error("fixed bits 2 to 5 not pin levels");
  a_fixed_bit6: assert property (@(posedge aclk) // R9
    disable iff (!aresetn)
    rvalid && $past(araddr) == OFF_FIXED && $rose(rvalid) |->
    rdata[6] == 1'b0)
    else $error("fixed bit 6 not zero");
  a_fixed_refused: assert property (@(posedge aclk) // R13
    disable iff (!aresetn)
    clk_en && do_write && aw_addr_q == OFF_FIXED |=>
    bvalid && bresp == RESP_SLVERR)
    else $error("fixed port write accepted");
  a_rx_follows: assert property (@(posedge aclk) // R14
    disable iff (!aresetn)
    aresetn && clk_en |=> async_receive_in == $past(fixed_sync[0]))
    else $error("receive input not fixed bit 0");
  a_spi_follows: assert property (@(posedge aclk) // R15
    disable iff (!aresetn)
    aresetn && clk_en |=> spi_pins_in == $past(fixed_sync[5:2]))
    else $error("spi inputs not fixed bits 2 to 5");

  // Every accepted read is answered on the next edge
  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_en && arready && arvalid |=> rvalid)
    else $error("read not answered");

  // Main scenarios reached
  c_port_write: cover property (@(posedge aclk)
    do_write && aw_addr_q == OFF_A_DATA);
  c_dir_write: cover property (@(posedge aclk)
    do_write && aw_addr_q == OFF_B_DIR);
  c_fixed_read: cover property (@(posedge aclk)
    arready && arvalid && araddr == OFF_FIXED);
  c_async_both_on: cover property (@(posedge aclk)
    serial_ctrl[BIT_RX_ON] && serial_ctrl[BIT_TX_ON] && arready && arvalid);
  c_mixed_dir: cover property (@(posedge aclk)
    dir[0] != 8'h00 && dir[0] != 8'hFF);
endmodule : parallel_and_fixed_io_ports

// file: include/gpio_ports_pkg.sv
// Register map and reset values of the parallel and fixed port block.
// Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
package gpio_ports_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_A_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_B_DATA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_C_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FIXED = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_A_DIR = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_B_DIR = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_C_DIR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_SERIAL_CTRL = 8'h1C;
  // Serial control field positions
  localparam int unsigned BIT_RX_ON = 0;
  localparam int unsigned BIT_TX_ON = 1;
  localparam int unsigned BIT_SPI_ON = 2;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [2:0] SERIAL_CTRL_RESET = 3'h0;
  localparam logic [7:0] FIXED_MASK = 8'hBF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpio_ports_pkg

// file: testbench/pin_partner.sv
// External device on one 8-bit port: resolves each pin's wire level.
// Assumes the block's out and enable pairs, enable high while driving.
`timescale 1ns/1ps
module pin_partner (
  // Block side of the pins
  input wire logic [7:0] drive,
  input wire logic [7:0] enable,
  // Level the outside device applies while a pin is released
  input wire logic [7:0] ext,
  // High while the outside device overpowers even the driven pins
  input wire logic overpower,
  // Resolved wire level fed back to the block
  output logic [7:0] level
);
  // Per bit, the block wins while it drives unless overpowered
  assign level = overpower ? ext : (drive & enable) | (ext & ~enable);
endmodule : pin_partner

// file: testbench/testbench.sv
// Self-checking bench for the parallel and fixed port block.
// Assumes the package, the design top and pin_partner are compiled.
`timescale 1ns/1ps
module testbench;
  import gpio_ports_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic async_receiver_on, async_transmitter_on, spi_system_on;
  logic async_receive_in, run, fight;
  logic [3:0] spi_pins_in, strb;
  logic [7:0] awaddr, araddr, fixed_input_pins, d, m, f, c;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] ext [3];
  logic [7:0] pout [3];
  logic [7:0] poe [3];
  logic [7:0] pin [3];
  logic [1:0] exp_b [$];
  logic [33:0] exp_r [$];
  int failures, n_compared;

  // Free running 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  parallel_and_fixed_io_ports u_parallel_and_fixed_io_ports (
    .aclk, .aresetn, .clk_en(run), .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(strb), .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp,
    .first_port_pins_in(pin[0]), .first_port_pins_out(pout[0]),
    .first_port_pins_oe(poe[0]), .second_port_pins_in(pin[1]),
    .second_port_pins_out(pout[1]), .second_port_pins_oe(poe[1]),
    .third_port_pins_in(pin[2]), .third_port_pins_out(pout[2]),
    .third_port_pins_oe(poe[2]), .fixed_input_pins, .async_receiver_on,
    .async_transmitter_on, .spi_system_on, .async_receive_in,
    .spi_pins_in);

  // One outside device per bidirectional port
  for (genvar i = 0; i < 3; i++)
  begin : g_pins
    pin_partner u_pin_partner (.drive(pout[i]), .enable(poe[i]),
      .ext(ext[i]), .overpower(fight), .level(pin[i]));
  end

  // Counts a comparison and reports a miss
  task automatic note(input bit ok);
    n_compared++;
    if (!ok)
    begin
      failures++;
      $display("unexpected at %0t: result differs", $time);
    end
  endtask : note
  // Error replies carry no meaningful data, so only the code is compared
  task automatic cmp_read(input logic [33:0] got, input logic [33:0] exp);
    note(exp[33:32] === RESP_OKAY ? got === exp : got[33:32] === exp[33:32]);
  endtask : cmp_read
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    note(got === exp);
  endtask : cmp_resp
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp);
  endtask : cmp_pin

  // Takes the oldest note off each queue when a response is accepted
  always @(posedge aclk)
  begin
    if (rvalid === 1'b1 && rready && exp_r.size() > 0)
      cmp_read({rresp, rdata}, exp_r.pop_front());
    if (bvalid === 1'b1 && bready && exp_b.size() > 0)
      cmp_resp(bresp, exp_b.pop_front());
  end

  // Write with address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) bready <= 1'b0;
    end while (awvalid || wvalid || bready);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] r);
    exp_r.push_back({r, 24'h0, v});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) rready <= 1'b0;
    end while (arvalid || rready);
  endtask : rd

  // State every reset must leave behind
  task automatic check_reset();
    for (int p = 0; p < 3; p++)
    begin
      cmp_pin(poe[p], 8'h00);
      rd(OFF_A_DIR + 8'(4 * p), 8'h00, RESP_OKAY);
    end
    cmp_pin({5'h0, async_receiver_on, async_transmitter_on, spi_system_on},
            8'h00);
    rd(OFF_SERIAL_CTRL, 8'h00, RESP_OKAY);
  endtask : check_reset

  task automatic end_of_test();
    if (failures == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  // Watchdog far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    failures++;
    end_of_test();
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, fixed_input_pins} = '0;
    run = 1'b1;
    fight = 1'b0;
    strb = 4'hF;
    ext = '{8'h00, 8'h00, 8'h00};
    void'($urandom(44));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset();
    // Random latch, direction and outside levels on each port
    for (int p = 0; p < 3; p++)
    begin
      d = 8'($urandom);
      m = 8'($urandom);
      ext[p] <= 8'($urandom);
      wr(OFF_A_DATA + 8'(4 * p), d, RESP_OKAY);
      wr(OFF_A_DIR + 8'(4 * p), m, RESP_OKAY);
      rd(OFF_A_DIR + 8'(4 * p), m, RESP_OKAY);
      repeat (3) @(posedge aclk);
      cmp_pin(poe[p], m);
      cmp_pin(pout[p] & m, d & m);
      rd(OFF_A_DATA + 8'(4 * p), (d & m) | (ext[p] & ~m), RESP_OKAY);
      // Outputs still read the latch while the outside forces the pins
      fight <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(OFF_A_DATA + 8'(4 * p), (d & m) | (ext[p] & ~m), RESP_OKAY);
      fight <= 1'b0;
    end
    // Fixed port under every mix of serial enables
    for (int k = 0; k < 8; k++)
    begin
      c = 8'(k);
      f = 8'($urandom);
      fixed_input_pins <= f;
      wr(OFF_SERIAL_CTRL, c, RESP_OKAY);
      rd(OFF_SERIAL_CTRL, c, RESP_OKAY);
      repeat (3) @(posedge aclk);
      cmp_pin({5'h0, async_receiver_on, async_transmitter_on, spi_system_on},
              {5'h0, c[0], c[1], c[2]});
      cmp_pin({4'h0, spi_pins_in}, {4'h0, f[5:2]});
      cmp_pin({7'h0, async_receive_in}, {7'h0, f[0]});
      rd(OFF_FIXED, (f & FIXED_MASK) & ((c[1:0] == 2'h3) ? 8'hFC : 8'hFF),
         RESP_OKAY);
    end
    // Pin changes wait while the clock enable is low
    run <= 1'b0;
    fixed_input_pins <= ~f;
    repeat (4) @(posedge aclk);
    cmp_pin({7'h0, async_receive_in}, {7'h0, f[0]});
    run <= 1'b1;
    repeat (4) @(posedge aclk);
    cmp_pin({7'h0, async_receive_in}, {7'h0, ~f[0]});
    fixed_input_pins <= f;
    repeat (3) @(posedge aclk);
    // Writes to the fixed port and unmapped places are refused
    wr(OFF_FIXED, ~f, RESP_SLVERR);
    rd(OFF_FIXED, f & FIXED_MASK & 8'hFC, RESP_OKAY);
    wr(8'h20, 8'h5A, RESP_SLVERR);
    rd(8'h20, 8'h00, RESP_SLVERR);
    // A write without its low lane stores a zero low byte
    strb <= 4'hE;
    wr(OFF_A_DIR, 8'hFF, RESP_OKAY);
    strb <= 4'hF;
    rd(OFF_A_DIR, 8'h00, RESP_OKAY);
    // Reset in mid-run with outputs and serial enables active
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check_reset();
    end_of_test();
  end
endmodule : testbench
